// ==== prox_cfg.svh ====
// timing constants and sizes for the proximity scan controller
`ifndef PROX_CFG_SVH
`define PROX_CFG_SVH
`define CLK_PERIOD_PS 5000
`define NORMAL_SLEEP_MIN_US 69000
`define NORMAL_SLEEP_MAX_US 105000
`define LOWPWR_SLEEP_MIN_US 572000
`define LOWPWR_SLEEP_MAX_US 845000
`define US_TO_CYCLES(us) ((64'd1000000 * (us) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SENSE_W 8
`define SCAN_CYCLES 16
`define TIMER_W 28
`define TOUCH_DELTA 8'hf0
`define STUCK_SCANS 255
`endif

// ==== prox_pkg.sv ====
// types for the proximity scan controller
package prox_pkg;
    typedef enum logic [1:0] {
        ST_SCAN = 2'b00,
        ST_EVAL = 2'b01,
        ST_SLEEP = 2'b10
    } scan_state_t;
    typedef enum logic [1:0] {
        REL_IDLE = 2'b00,
        REL_TOUCHED = 2'b01
    } release_state_t;
endpackage

// ==== sleep_timer.sv ====
// sleep interval down-counter
`timescale 1ns/1ps
`include "prox_cfg.svh"
module sleep_timer #(
    parameter int W = `TIMER_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // control
    input wire logic load,
    input wire logic [W-1:0] load_value,
    input wire logic abort,
    // status
    output logic expired
);
    logic [W-1:0] count_reg;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
        end else if (abort) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= load_value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - W'(1);
        end
    end

    assign expired = (count_reg == '0);
endmodule

// ==== proximity_scan_controller.sv ====
// scan scheduling, detection and release logic of the proximity detector
`timescale 1ns/1ps
`include "prox_cfg.svh"
// Contract
// - sample sensitivity after each completed scan; use it for later detections.
// - sensitivity level at rail means least sensitive, ground means most sensitive.
// - mode select high and nothing detected gives normal mode.
// - normal mode sleeps 69 to 105 ms between scans.
// - mode select low and nothing detected gives low-power mode.
// - low-power mode sleeps 572 to 845 ms between scans.
// - while detected, scan back to back with no sleep.
// - on release, resume the schedule of the currently selected mode.
// - any edge of mode select resets detection and clears detected state.
// - mode-pin reset is accepted at any moment.
// - stuck detection released by touch on the pad then its removal.
// - detect output low while proximity or touch is detected.
// - detect output is open drain: only pulls low, otherwise floats.
module proximity_scan_controller
#(
    parameter int SENSE_W = `SENSE_W,
    parameter int TIMER_W = `TIMER_W,
    parameter int SCAN_CYCLES = `SCAN_CYCLES,
    parameter logic [TIMER_W-1:0] NORMAL_SLEEP = TIMER_W'(`US_TO_CYCLES(`NORMAL_SLEEP_MIN_US)),
    parameter logic [TIMER_W-1:0] LOWPWR_SLEEP = TIMER_W'(`US_TO_CYCLES(`LOWPWR_SLEEP_MIN_US)),
    parameter logic [SENSE_W-1:0] TOUCH_DELTA = SENSE_W'(`TOUCH_DELTA),
    parameter int STUCK_SCANS = `STUCK_SCANS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // sensor front end: measured change against baseline, new value each cycle
    input wire logic [SENSE_W-1:0] sensor_input,
    // sensitivity level, all ones at the rail, zero at ground
    input wire logic [SENSE_W-1:0] sensitivity_adjust,
    // power mode select, low selects low-power mode
    input wire logic low_power_select_n,
    // open-drain detect output
    input wire logic detect_out_n_i,
    output logic detect_out_n_o,
    output logic detect_out_n_oe,
    // status
    output logic scanning,
    output prox_pkg::scan_state_t scan_state
);
    import prox_pkg::*;

    scan_state_t state_reg;
    release_state_t rel_reg;
    logic [$clog2(SCAN_CYCLES+1)-1:0] scan_cnt_reg;
    logic [SENSE_W-1:0] threshold_reg;
    logic [SENSE_W-1:0] peak_reg;
    logic detected_reg;
    logic mode_prev_reg;
    logic mode_valid_reg;
    localparam int STUCK_W = $clog2(STUCK_SCANS + 1);
    logic [STUCK_W-1:0] stuck_cnt_reg;
    logic mode_edge;
    logic scan_done;
    logic over;
    logic is_touch;
    logic timer_load;
    logic timer_expired;
    logic [TIMER_W-1:0] sleep_value;
    logic det_next;

    // edge seen only after the first sampled level, so release from reset is no edge
    assign mode_edge = mode_valid_reg && (low_power_select_n != mode_prev_reg);
    assign scan_done = (state_reg == ST_SCAN) && (scan_cnt_reg == SCAN_CYCLES - 1);
    assign over = peak_reg > threshold_reg;
    assign is_touch = peak_reg >= TOUCH_DELTA;
    // shortest interval chosen: response time favoured over power
    assign sleep_value = low_power_select_n ? NORMAL_SLEEP : LOWPWR_SLEEP;
    // armed only when the evaluation leads into sleep, a release included
    assign timer_load = (state_reg == ST_EVAL) && !det_next;

    // next detection state, shared by the sequencer and the sleep timer load
    always_comb begin
        det_next = detected_reg;
        if (state_reg == ST_EVAL) begin
            if (!detected_reg) begin
                det_next = over;
            end else if (!over) begin
                det_next = 1'b0;
            end else if (rel_reg == REL_TOUCHED && !is_touch) begin
                det_next = 1'b0;
            end
        end
    end

    sleep_timer #(
        .W(TIMER_W)
    ) u_sleep (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(timer_load),
        .load_value(sleep_value),
        .abort(mode_edge),
        .expired(timer_expired)
    );

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_prev_reg <= 1'b1;
            mode_valid_reg <= 1'b0;
        end else begin
            mode_prev_reg <= low_power_select_n;
            mode_valid_reg <= 1'b1;
        end
    end

    // scan sequencer
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_SCAN;
            scan_cnt_reg <= '0;
        end else if (mode_edge) begin
            state_reg <= ST_SCAN;
            scan_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_SCAN: begin
                    if (scan_done) begin
                        state_reg <= ST_EVAL;
                        scan_cnt_reg <= '0;
                    end else begin
                        scan_cnt_reg <= scan_cnt_reg + 1'b1;
                    end
                end
                ST_EVAL: begin
                    // decided on the new detection state, so a release sleeps at once
                    if (det_next) begin
                        state_reg <= ST_SCAN;
                    end else begin
                        state_reg <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (timer_expired) begin
                        state_reg <= ST_SCAN;
                    end
                end
                default: begin
                    state_reg <= ST_SCAN;
                end
            endcase
        end
    end

    // peak of the change over one scan
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            peak_reg <= '0;
        end else if (mode_edge || state_reg == ST_EVAL) begin
            peak_reg <= '0;
        end else if (state_reg == ST_SCAN && sensor_input > peak_reg) begin
            peak_reg <= sensor_input;
        end
    end

    // threshold taken after each scan; higher level means higher threshold, less sensitive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            threshold_reg <= '1;
        end else if (state_reg == ST_EVAL) begin
            threshold_reg <= sensitivity_adjust;
        end
    end

    // detection state with mode-pin reset and touch-and-release stuck release
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            detected_reg <= 1'b0;
            rel_reg <= REL_IDLE;
            stuck_cnt_reg <= '0;
        end else if (mode_edge) begin
            // a mode edge outranks an evaluation in the same cycle
            detected_reg <= 1'b0;
            rel_reg <= REL_IDLE;
            stuck_cnt_reg <= '0;
        end else if (state_reg == ST_EVAL) begin
            if (!detected_reg) begin
                detected_reg <= over;
                stuck_cnt_reg <= '0;
                rel_reg <= REL_IDLE;
            end else if (!over) begin
                detected_reg <= 1'b0;
                rel_reg <= REL_IDLE;
            end else begin
                if (stuck_cnt_reg != STUCK_W'(STUCK_SCANS)) begin
                    stuck_cnt_reg <= stuck_cnt_reg + STUCK_W'(1);
                end
                // a stuck detection is one held for many scans; touch then lift frees it
                unique case (rel_reg)
                    REL_IDLE: begin
                        if (stuck_cnt_reg == STUCK_W'(STUCK_SCANS) && is_touch) begin
                            rel_reg <= REL_TOUCHED;
                        end
                    end
                    REL_TOUCHED: begin
                        if (!is_touch) begin
                            detected_reg <= 1'b0;
                            rel_reg <= REL_IDLE;
                            stuck_cnt_reg <= '0;
                        end
                    end
                    default: begin
                        rel_reg <= REL_IDLE;
                    end
                endcase
            end
        end
    end

    // open drain: low while detected, released otherwise
    assign detect_out_n_o = 1'b0;
    assign detect_out_n_oe = detected_reg;
    assign scanning = (state_reg == ST_SCAN);
    assign scan_state = state_reg;
endmodule

// ==== scan_checker.sv ====
// port assertions for the proximity scan controller
`timescale 1ns/1ps
module scan_checker
    import prox_pkg::*;
#(
    parameter logic [27:0] NORMAL_SLEEP = 28'h14,
    parameter logic [27:0] LOWPWR_SLEEP = 28'h28
) (
    // watched ports
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic low_power_select_n,
    input wire logic detect_out_n_o,
    input wire logic detect_out_n_oe,
    input wire logic scanning,
    input wire prox_pkg::scan_state_t scan_state
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    int sleep_cnt;
    logic cut;
    // a mode edge cuts a sleep short, so such sleeps are not measured
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sleep_cnt <= 0;
            cut <= 1'b0;
        end else begin
            sleep_cnt <= (scan_state == ST_SLEEP) ? sleep_cnt + 1 : 0;
            cut <= (scan_state == ST_SLEEP) && (cut || $changed(low_power_select_n));
        end
    end
    sequence eval_calm;
        $stable(low_power_select_n) ##1 scan_state == ST_EVAL && $stable(low_power_select_n)
        ##1 $stable(low_power_select_n);
    endsequence
    idle_sleep_a: assert property (eval_calm ##0 !detect_out_n_oe |-> scan_state == ST_SLEEP)
        else $error("no sleep after idle scan");
    det_loop_a: assert property (eval_calm ##0 detect_out_n_oe |-> scan_state == ST_SCAN)
        else $error("sleep while detected");
    mode_edge_a: assert property ($changed(low_power_select_n) |-> ##[1:2] (scan_state == ST_SCAN && !detect_out_n_oe))
        else $error("mode edge not handled");
    scan_len_a: assert property (scan_state == ST_EVAL |-> $past(scanning, 16) && $past(scanning))
        else $error("scan too short");
    sleep_len_a: assert property ($past(scan_state) == ST_SLEEP && scanning && !cut && $stable(low_power_select_n)
        |-> sleep_cnt == (low_power_select_n ? NORMAL_SLEEP + 1 : LOWPWR_SLEEP + 1))
        else $error("sleep length wrong");
    drive_low_a: assert property (detect_out_n_oe |-> !detect_out_n_o)
        else $error("pad driven high");
    scan_flag_a: assert property (scanning == (scan_state == ST_SCAN))
        else $error("scanning flag wrong");
    det_rise_a: assert property ($rose(detect_out_n_oe) |-> $past(scan_state) == ST_EVAL)
        else $error("detect outside eval");
endmodule
bind proximity_scan_controller scan_checker #(.NORMAL_SLEEP(NORMAL_SLEEP), .LOWPWR_SLEEP(LOWPWR_SLEEP))
    scan_checker_i (.ref_clk(ref_clk), .reset(reset), .low_power_select_n(low_power_select_n),
    .detect_out_n_o(detect_out_n_o), .detect_out_n_oe(detect_out_n_oe), .scanning(scanning),
    .scan_state(scan_state));

// ==== host_model.sv ====
// host side: pull-up on the detect line and the mode select driver
`timescale 1ns/1ps
module host_model #(
    parameter int PULSE_MIN = 4
) (
    // clock
    input wire logic ref_clk,
    // detect line
    input wire logic drive_n_o,
    input wire logic drive_n_oe,
    output wire logic pad,
    // mode select
    output logic mode_n
);
    assign pad = drive_n_oe ? drive_n_o : 1'b1;
    initial mode_n = 1'b1;
    task automatic set_mode(input logic v);
        @(posedge ref_clk);
        mode_n <= v;
    endtask
    // pulse scaled down, the device samples the pin every cycle
    task automatic reset_pulse(input int sleep_cycles);
        @(posedge ref_clk);
        mode_n <= ~mode_n;
        repeat (PULSE_MIN + sleep_cycles) @(posedge ref_clk);
        mode_n <= ~mode_n;
    endtask
endmodule

// ==== proximity_scan_controller_tb.sv ====
// testbench for the proximity scan controller
`timescale 1ns/1ps
module proximity_scan_controller_tb;
    import prox_pkg::*;
    localparam logic [27:0] NS = 28'h14;
    localparam logic [27:0] LS = 28'h28;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sensor_input = 8'h00;
    logic [7:0] sensitivity_adjust = 8'h80;
    wire logic pad, mode_n, oe, drv;
    logic scanning;
    scan_state_t scan_state;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    host_model host_i (.ref_clk(ref_clk), .drive_n_o(drv), .drive_n_oe(oe), .pad(pad),
        .mode_n(mode_n));
    proximity_scan_controller #(.NORMAL_SLEEP(NS), .LOWPWR_SLEEP(LS), .STUCK_SCANS(3))
        proximity_scan_controller_i (.ref_clk(ref_clk), .reset(reset),
        .sensor_input(sensor_input), .sensitivity_adjust(sensitivity_adjust),
        .low_power_select_n(mode_n), .detect_out_n_i(pad), .detect_out_n_o(drv),
        .detect_out_n_oe(oe), .scanning(scanning), .scan_state(scan_state));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits for an eval, loads the next scan value, returns with the result of the previously loaded value out
    task step(input logic [7:0] v);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (scan_state !== ST_EVAL && n < 100);
        @(posedge ref_clk);
        sensor_input <= v;
        #1;
    endtask
    task t_sched(input logic m, input logic [27:0] exp);
        int n;
        n = 0;
        host_i.set_mode(m);
        repeat (3) @(posedge ref_clk);
        step(8'h00);
        while (scan_state === ST_SLEEP && n < 100) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk(n, exp + 1);
        $display("sched %0d done", m);
    endtask
    task t_detect;
        step(8'h81);
        step(8'h80);
        chk(pad, 0);
        chk(scan_state, ST_SCAN);
        step(8'h00);
        chk(pad, 1);
        chk(scan_state, ST_SLEEP);
        @(posedge ref_clk);
        sensitivity_adjust <= 8'h40;
        step(8'h50);
        step(8'h00);
        chk(pad, 0);
        step(8'h00);
        chk(pad, 1);
        @(posedge ref_clk);
        sensitivity_adjust <= 8'h80;
        $display("detect done");
    endtask
    task t_clear;
        step(8'h90);
        step(8'h90);
        chk(pad, 0);
        host_i.reset_pulse(0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(pad, 1);
        repeat (6) step(8'h90);
        chk(pad, 0);
        step(8'hf8);
        step(8'h90);
        step(8'h00);
        chk(pad, 1);
        $display("clear done");
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        t_sched(1'b1, NS);
        t_sched(1'b0, LS);
        t_detect();
        t_clear();
        conclude();
    end
endmodule
